// ===== core/mpop_pkg.sv
// Constants shared by the multipurpose output port block
package mpop_pkg;
    // Register byte offsets on the bus
    localparam logic [5:0] OFF_PIN_CONFIG = 6'h00;
    localparam logic [5:0] OFF_START_STROBE = 6'h04;
    localparam logic [5:0] OFF_STOP_STROBE = 6'h08;
    localparam logic [5:0] OFF_SET_STROBE = 6'h0C;
    localparam logic [5:0] OFF_CLEAR_STROBE = 6'h10;
    localparam logic [5:0] OFF_ALT_SELECT = 6'h14;
    localparam logic [5:0] OFF_CHAN_A_COMMAND = 6'h18;
    localparam logic [5:0] OFF_CHAN_B_COMMAND = 6'h1C;
    localparam logic [5:0] OFF_PIN_STATUS = 6'h20;
    // Field positions in output_pin_config
    localparam int OP2_SEL_LSB = 0;
    localparam int OP3_SEL_LSB = 2;
    localparam int OP4_SEL_BIT = 4;
    localparam int OP5_SEL_BIT = 5;
    localparam int OP6_SEL_BIT = 6;
    localparam int OP7_SEL_BIT = 7;
    // Two-bit source codes for pins 2 and 3
    localparam logic [1:0] SRC_LATCH = 2'h0;
    localparam logic [1:0] SRC_ALT1 = 2'h1;
    localparam logic [1:0] SRC_ALT2 = 2'h2;
    localparam logic [1:0] SRC_ALT3 = 2'h3;
    // Mode-bit copies in alt_select
    localparam int ALT_A_MODE1_BIT = 0;
    localparam int ALT_A_MODE2_BIT = 1;
    localparam int ALT_B_MODE1_BIT = 2;
    localparam int ALT_B_MODE2_BIT = 3;
    // Channel command field and codes
    localparam int CMD_LSB = 4;
    localparam logic [3:0] CMD_RTS_ASSERT = 4'h8;
    localparam logic [3:0] CMD_RTS_NEGATE = 4'h9;
    // Field positions in pin_status
    localparam int STAT_CFG_LSB = 8;
    localparam int STAT_GP_LSB = 16;
    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] PINS_RESET = 8'hFF;
    localparam logic [3:0] ALT_RESET = 4'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;
endpackage : mpop_pkg

// ===== core/mpop_gp_latch.sv
// General-purpose output latches with set and clear strobes
`timescale 1ns/10ps
module mpop_gp_latch import mpop_pkg::*; (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Strobe masks and alternate-function mask
    input wire logic [7:0] set_mask_i,
    input wire logic [7:0] clear_mask_i,
    input wire logic [7:0] alt_mask_i,
    // Latch state, 1 means asserted (pin low)
    output logic [7:0] asserted_o
);
    // All state of the latch
    typedef struct packed {
        logic [7:0] asserted;
    } mpop_gp_state_t;

    mpop_gp_state_t state;
    mpop_gp_state_t next_state;

    // Pins on alternate functions ignore both strobes
    always_comb begin
        next_state = state;
        next_state.asserted = (state.asserted | (set_mask_i & ~alt_mask_i))
                              & ~(clear_mask_i & ~alt_mask_i);
    end

    // Reset negates every latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.asserted <= ~PINS_RESET;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    assign asserted_o = state.asserted;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    set_takes_hold_a: assert property (
        ce_i && set_mask_i[0] && !alt_mask_i[0] && !clear_mask_i[0]
        |=> asserted_o[0])
        else $error("set strobe did not assert latch");
    clear_releases_a: assert property (
        ce_i && clear_mask_i[3] && !alt_mask_i[3]
        |=> !asserted_o[3])
        else $error("clear strobe did not negate latch");
    held_until_clear_a: assert property (
        ce_i && asserted_o[5] && !clear_mask_i[5]
        |=> asserted_o[5])
        else $error("latch released without clear");
    // Only fires when a strobe really hits an alternate pin
    alt_blocks_strobe_a: assert property (
        ce_i && alt_mask_i[4] && (set_mask_i[4] || clear_mask_i[4])
        |=> asserted_o[4] == $past(asserted_o[4]))
        else $error("strobe changed alternate pin latch");
endmodule : mpop_gp_latch

// ===== core/mpop_ct_output.sv
// Counter/timer output shaping for pin 3
`timescale 1ns/10ps
module mpop_ct_output import mpop_pkg::*; (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Counter/timer inputs
    input wire logic timer_mode_i,
    input wire logic terminal_count_i,
    input wire logic square_wave_i,
    input wire logic stop_cmd_i,
    // Shaped output
    output logic ct_out_o
);
    // All state of the shaper
    typedef struct packed {
        logic reached;
        logic out;
    } mpop_ct_state_t;

    mpop_ct_state_t state;
    mpop_ct_state_t next_state;

    // Counter mode: low from terminal count until a stop
    always_comb begin
        next_state = state;
        if (stop_cmd_i) begin
            next_state.reached = 1'b0;
        end else if (terminal_count_i && !timer_mode_i) begin
            next_state.reached = 1'b1;
        end
        // Timer mode passes the square wave, a stop does not touch it
        next_state.out = timer_mode_i ? square_wave_i : ~next_state.reached;
    end

    // Output idles high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.reached <= 1'b0;
            state.out <= 1'b1;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    assign ct_out_o = state.out;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    count_goes_low_a: assert property (
        ce_i && !timer_mode_i && terminal_count_i && !stop_cmd_i
        |=> !ct_out_o)
        else $error("terminal count did not drive output low");
    stop_restores_a: assert property (
        ce_i && !timer_mode_i && stop_cmd_i
        |=> ct_out_o)
        else $error("stop did not return output high");
    timer_passes_a: assert property (
        ce_i && timer_mode_i
        |=> ct_out_o == $past(square_wave_i))
        else $error("timer square wave not passed");
endmodule : mpop_ct_output

// ===== core/mpop_port.sv
// Multipurpose output port with Wishbone register access
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - Config bits 1:0 pick pin 2 source
// - Config bits 3:2 pick pin 3 source
// - Bit 4: pin 4 inverse rx ready A
// - Bit 5: pin 5 inverse rx ready B
// - Bit 6: pin 6 inverse tx ready A
// - Bit 7: pin 7 inverse tx ready B
// - Pins 0 and 1 chosen by mode bits
// - Counter output low at terminal, high on stop
// - Reading start strobe starts counter/timer
// - Reading stop strobe stops the counter, not the timer
// - Set write asserts latches with ones
// - Clear write negates latches with ones
// - Asserted latch holds until a clear
// - Strobes ignore alternate-function pins
// - Commands 0x8/0x9 assert/negate request-to-send
// - Stop in timer mode only clears ready
module mpop_port import mpop_pkg::*; (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Baud-rate clocks from the channels
    input wire logic chan_a_tx_clock_x16_i,
    input wire logic chan_a_tx_clock_x1_i,
    input wire logic chan_a_rx_clock_x1_i,
    input wire logic chan_b_tx_clock_x1_i,
    input wire logic chan_b_rx_clock_x1_i,
    // Ready flags from interrupt status, active high
    input wire logic chan_a_tx_ready_i,
    input wire logic chan_a_rx_ready_i,
    input wire logic chan_b_tx_ready_i,
    input wire logic chan_b_rx_ready_i,
    // Counter/timer interface
    input wire logic timer_mode_i,
    input wire logic ct_terminal_count_i,
    input wire logic ct_square_wave_i,
    output logic timer_start_o,
    output logic timer_halt_o,
    output logic ct_ready_clear_o,
    // Output pins, active low
    output logic [7:0] multipurpose_out_o
);
    // All state of the port
    typedef struct packed {
        logic [7:0] cfg;
        logic [3:0] alt;
        logic rts_a;
        logic rts_b;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] pins;
        logic start;
        logic halt;
        logic rdy_clear;
    } mpop_state_t;

    mpop_state_t state;
    mpop_state_t next_state;

    // Four-way source pick for pins 2 and 3
    function automatic logic mpop_pick4(input logic [1:0] code,
                                        input logic latch_n,
                                        input logic s1,
                                        input logic s2,
                                        input logic s3);
        logic r;
        r = latch_n;
        unique case (code)
            SRC_LATCH: r = latch_n;
            SRC_ALT1: r = s1;
            SRC_ALT2: r = s2;
            SRC_ALT3: r = s3;
        endcase
        return r;
    endfunction : mpop_pick4

    // Two-way pick: alternate level or latch level
    function automatic logic mpop_pick2(input logic use_alt,
                                        input logic alt_n,
                                        input logic latch_n);
        return use_alt ? alt_n : latch_n;
    endfunction : mpop_pick2

    // Bus decode helpers
    logic req;
    logic wr;
    logic rd;
    logic lane0;
    logic [7:0] set_mask;
    logic [7:0] clear_mask;
    logic [7:0] alt_mask;
    logic [7:0] gp_asserted;
    logic ct_out;
    logic stop_cmd;

    // A request is taken once, in the cycle before ack rises
    always_comb begin
        req = cyc_i && stb_i && !state.ack;
        wr = req && we_i;
        rd = req && !we_i;
        // Only lane 0 carries write data
        lane0 = sel_i[0];
        set_mask = (wr && lane0 && adr_i[5:2] == OFF_SET_STROBE[5:2])
                   ? dat_i[7:0] : 8'h00;
        clear_mask = (wr && lane0 && adr_i[5:2] == OFF_CLEAR_STROBE[5:2])
                     ? dat_i[7:0] : 8'h00;
        stop_cmd = rd && adr_i[5:2] == OFF_STOP_STROBE[5:2];
    end

    // Which pins currently serve an alternate function
    always_comb begin
        alt_mask[0] = state.alt[ALT_A_MODE1_BIT] | state.alt[ALT_A_MODE2_BIT];
        alt_mask[1] = state.alt[ALT_B_MODE1_BIT] | state.alt[ALT_B_MODE2_BIT];
        // Pins 2 and 3 leave the latch for any nonzero code
        alt_mask[2] = state.cfg[OP2_SEL_LSB +: 2] != SRC_LATCH;
        alt_mask[3] = state.cfg[OP3_SEL_LSB +: 2] != SRC_LATCH;
        // Pins 4 to 7 switch on their own config bit
        alt_mask[7:4] = state.cfg[OP7_SEL_BIT:OP4_SEL_BIT];
    end

    // Set/clear latches
    mpop_gp_latch u_gp_latch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_mask_i(set_mask),
        .clear_mask_i(clear_mask),
        .alt_mask_i(alt_mask),
        .asserted_o(gp_asserted)
    );

    // Counter/timer output shaper
    mpop_ct_output u_ct_output (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .timer_mode_i(timer_mode_i),
        .terminal_count_i(ct_terminal_count_i),
        .square_wave_i(ct_square_wave_i),
        .stop_cmd_i(stop_cmd),
        .ct_out_o(ct_out)
    );

    // Register file, strobes and pin steering
    always_comb begin
        next_state = state;
        // Ack follows a taken request by one edge
        next_state.ack = req;
        // Strobes and read data idle unless a read sets them
        next_state.rdata = RDATA_ZERO;
        next_state.start = 1'b0;
        next_state.halt = 1'b0;
        next_state.rdy_clear = 1'b0;
        // Writes need lane 0; unmapped offsets are acked and ignored
        if (wr && lane0) begin
            unique case (adr_i[5:2])
                OFF_PIN_CONFIG[5:2]: next_state.cfg = dat_i[7:0];
                OFF_ALT_SELECT[5:2]: next_state.alt = dat_i[3:0];
                OFF_CHAN_A_COMMAND[5:2]: begin
                    // Request-to-send commands for channel A
                    if (dat_i[CMD_LSB +: 4] == CMD_RTS_ASSERT) begin
                        next_state.rts_a = 1'b1;
                    end else if (dat_i[CMD_LSB +: 4] == CMD_RTS_NEGATE) begin
                        next_state.rts_a = 1'b0;
                    end
                end
                OFF_CHAN_B_COMMAND[5:2]: begin
                    // Same command codes for channel B
                    if (dat_i[CMD_LSB +: 4] == CMD_RTS_ASSERT) begin
                        next_state.rts_b = 1'b1;
                    end else if (dat_i[CMD_LSB +: 4] == CMD_RTS_NEGATE) begin
                        next_state.rts_b = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Reads; strobe registers return zero, meaning nothing
        if (rd) begin
            unique case (adr_i[5:2])
                OFF_START_STROBE[5:2]: next_state.start = 1'b1;
                OFF_STOP_STROBE[5:2]: begin
                    // Timer mode keeps running, only ready flag clears
                    next_state.halt = !timer_mode_i;
                    next_state.rdy_clear = 1'b1;
                end
                OFF_PIN_STATUS[5:2]: begin
                    next_state.rdata[7:0] = state.pins;
                    next_state.rdata[STAT_CFG_LSB +: 8] = state.cfg;
                    next_state.rdata[STAT_GP_LSB +: 8] = gp_asserted;
                end
                default: ;
            endcase
        end
        // Pins 0 and 1: request-to-send when a mode bit selects it
        next_state.pins[0] = mpop_pick2(alt_mask[0], ~state.rts_a, ~gp_asserted[0]);
        next_state.pins[1] = mpop_pick2(alt_mask[1], ~state.rts_b, ~gp_asserted[1]);
        // Pin 2: channel A baud clocks
        next_state.pins[2] = mpop_pick4(state.cfg[OP2_SEL_LSB +: 2], ~gp_asserted[2],
                                        chan_a_tx_clock_x16_i, chan_a_tx_clock_x1_i,
                                        chan_a_rx_clock_x1_i);
        // Pin 3: counter/timer or channel B clocks
        next_state.pins[3] = mpop_pick4(state.cfg[OP3_SEL_LSB +: 2], ~gp_asserted[3],
                                        ct_out, chan_b_tx_clock_x1_i,
                                        chan_b_rx_clock_x1_i);
        // Pins 4 to 7: inverted ready flags
        next_state.pins[4] = mpop_pick2(state.cfg[OP4_SEL_BIT], ~chan_a_rx_ready_i,
                                        ~gp_asserted[4]);
        next_state.pins[5] = mpop_pick2(state.cfg[OP5_SEL_BIT], ~chan_b_rx_ready_i,
                                        ~gp_asserted[5]);
        next_state.pins[6] = mpop_pick2(state.cfg[OP6_SEL_BIT], ~chan_a_tx_ready_i,
                                        ~gp_asserted[6]);
        next_state.pins[7] = mpop_pick2(state.cfg[OP7_SEL_BIT], ~chan_b_tx_ready_i,
                                        ~gp_asserted[7]);
    end

    // Reset wins over the enable so a frozen block still resets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.cfg <= CFG_RESET;
            state.alt <= ALT_RESET;
            state.rts_a <= 1'b0;
            state.rts_b <= 1'b0;
            state.ack <= 1'b0;
            state.rdata <= RDATA_ZERO;
            state.pins <= PINS_RESET;
            state.start <= 1'b0;
            state.halt <= 1'b0;
            state.rdy_clear <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Every output straight from a flip-flop
    assign dat_o = state.rdata;
    assign ack_o = state.ack;
    assign timer_start_o = state.start;
    assign timer_halt_o = state.halt;
    assign ct_ready_clear_o = state.rdy_clear;
    assign multipurpose_out_o = state.pins;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Helper: a read of the start strobe offset taken this cycle
    logic start_rd;
    assign start_rd = ce_i && rd && adr_i[5:2] == OFF_START_STROBE[5:2];

    // Every taken request is answered on the next edge
    bus_ack_timing_a: assert property (
        ce_i && req
        |=> ack_o)
        else $error("ack missing after request");

    // Ack is a single-cycle pulse, even with the request held
    ack_single_a: assert property (
        ce_i && ack_o
        |=> !ack_o)
        else $error("ack held too long");

    // Pin 2 follows the 16x transmit clock when picked
    pin2_source_a: assert property (
        ce_i && state.cfg[OP2_SEL_LSB +: 2] == SRC_ALT1
        |=> multipurpose_out_o[2] == $past(chan_a_tx_clock_x16_i))
        else $error("pin 2 not 16x clock");

    // Pin 3 follows the channel B receive clock when picked
    pin3_source_a: assert property (
        ce_i && state.cfg[OP3_SEL_LSB +: 2] == SRC_ALT3
        |=> multipurpose_out_o[3] == $past(chan_b_rx_clock_x1_i))
        else $error("pin 3 not rx B clock");

    // Pin 4 shows receive ready A inverted
    pin4_ready_a: assert property (
        ce_i && state.cfg[OP4_SEL_BIT]
        |=> multipurpose_out_o[4] == !$past(chan_a_rx_ready_i))
        else $error("pin 4 not inverse ready");

    // Pin 5 shows receive ready B inverted
    pin5_ready_a: assert property (
        ce_i && state.cfg[OP5_SEL_BIT]
        |=> multipurpose_out_o[5] == !$past(chan_b_rx_ready_i))
        else $error("pin 5 not inverse ready");

    // Pin 6 shows transmit ready A inverted
    pin6_ready_a: assert property (
        ce_i && state.cfg[OP6_SEL_BIT]
        |=> multipurpose_out_o[6] == !$past(chan_a_tx_ready_i))
        else $error("pin 6 not inverse ready");

    // Pin 7 shows transmit ready B inverted
    pin7_ready_a: assert property (
        ce_i && state.cfg[OP7_SEL_BIT]
        |=> multipurpose_out_o[7] == !$past(chan_b_tx_ready_i))
        else $error("pin 7 not inverse ready");

    // A start read gives exactly one start pulse
    start_strobe_a: assert property (
        start_rd
        |=> timer_start_o ##1 (!timer_start_o || !$past(ce_i)))
        else $error("start strobe wrong");

    // A stop read always clears ready, halts only in counter mode
    stop_strobe_a: assert property (
        ce_i && stop_cmd
        |=> ct_ready_clear_o && (timer_halt_o != $past(timer_mode_i)))
        else $error("stop strobe wrong");

    // Assert command reaches pin 0 two edges later
    rts_command_a: assert property (
        ce_i && wr && lane0 && adr_i[5:2] == OFF_CHAN_A_COMMAND[5:2]
        && dat_i[CMD_LSB +: 4] == CMD_RTS_ASSERT && alt_mask[0]
        |=> ##1 (!multipurpose_out_o[0] || !$past(ce_i)))
        else $error("rts assert not shown on pin 0");

    // A set write reaches pin 7 through latch and pin register
    gp_set_pin_a: assert property (
        ce_i && set_mask[7] && !alt_mask[7]
        ##1 ce_i && !state.cfg[OP7_SEL_BIT]
        |=> !multipurpose_out_o[7])
        else $error("set write not seen on pin 7");

    // Main scenarios to be reached
    start_seen_c: cover property (
        timer_start_o);
    timer_on_pin3_c: cover property (
        state.cfg[OP3_SEL_LSB +: 2] == SRC_ALT1 && timer_mode_i);
    set_then_clear_c: cover property (
        set_mask != 8'h00 ##[1:20] clear_mask != 8'h00);
    rts_alt_c: cover property (
        alt_mask[0] && state.rts_a);
endmodule : mpop_port

// ===== verif/mpop_far_model.sv
// Far-side model: channel clocks, ready flags and a small counter/timer
`timescale 1ns/10ps
module mpop_far_model #(
    parameter int PRELOAD = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels commanded by the bench
    input wire logic [4:0] clk_lvl_i,
    input wire logic [3:0] rdy_i,
    // Counter/timer controls from the port
    input wire logic timer_mode_i,
    input wire logic timer_start_i,
    input wire logic timer_halt_i,
    // Clocks: tx16 A, tx1 A, rx1 A, tx1 B, rx1 B
    output logic [4:0] clk_lvl_o,
    // Ready flags: tx A, rx A, tx B, rx B
    output logic [3:0] rdy_o,
    // Counter/timer results
    output logic terminal_count_o,
    output logic square_wave_o
);
    logic [15:0] cnt; // Down counter
    logic run; // Counting in progress
    // Channel side is plain levels so each source can be pinned high or low
    assign clk_lvl_o = clk_lvl_i;
    assign rdy_o = rdy_i;
    // Counter reloads at zero; timer mode toggles and keeps running
    always_ff @(posedge clk_i) begin
        terminal_count_o <= 1'b0;
        if (rst_i) begin
            cnt <= 16'h0000;
            run <= 1'b0;
            square_wave_o <= 1'b1;
        end else if (timer_start_i) begin
            cnt <= 16'(PRELOAD);
            run <= 1'b1;
        end else if (timer_halt_i) begin
            // Halt only comes in counter mode, so a timer never stops here
            run <= 1'b0;
        end else if (run) begin
            if (cnt == 16'h0000) begin
                cnt <= 16'(PRELOAD);
                square_wave_o <= ~square_wave_o;
                terminal_count_o <= ~timer_mode_i;
                run <= timer_mode_i;
            end else begin
                cnt <= cnt - 16'h0001;
            end
        end
    end
endmodule : mpop_far_model

// ===== verif/tb.sv
// Self-checking bench for the multipurpose output port
`timescale 1ns/10ps
module tb import mpop_pkg::*; ();
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sel0 = 1'b0;
    logic [5:0] adr = 6'h00; // Bus address
    logic [7:0] wd = 8'h00; // Bus write data
    logic [31:0] dat_o, q; // Read data and last captured value
    logic ack_o, st_s, st_h, st_c, tmode = 1'b0, tc, sq, t_s, t_h, t_c;
    logic [4:0] lvl = 5'h00, f_clk; // Baud clock levels
    logic [3:0] rdy = 4'h0, f_rdy; // Ready flags
    logic [7:0] pins; // Active-low pins
    int error_cnt = 0, n_tests = 0, cyc_cnt = 0, t;
    // Clock at 25 MHz
    always #20 clk_i = ~clk_i;
    mpop_far_model far (.clk_i(clk_i), .rst_i(rst_i), .clk_lvl_i(lvl), .rdy_i(rdy),
        .timer_mode_i(tmode), .timer_start_i(t_s), .timer_halt_i(t_h), .clk_lvl_o(f_clk),
        .rdy_o(f_rdy), .terminal_count_o(tc), .square_wave_o(sq));
    mpop_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i({3'h0, sel0}), .dat_i({24'h000000, wd}),
        .dat_o(dat_o), .ack_o(ack_o), .chan_a_tx_clock_x16_i(f_clk[0]),
        .chan_a_tx_clock_x1_i(f_clk[1]), .chan_a_rx_clock_x1_i(f_clk[2]),
        .chan_b_tx_clock_x1_i(f_clk[3]), .chan_b_rx_clock_x1_i(f_clk[4]),
        .chan_a_tx_ready_i(f_rdy[0]), .chan_a_rx_ready_i(f_rdy[1]),
        .chan_b_tx_ready_i(f_rdy[2]), .chan_b_rx_ready_i(f_rdy[3]), .timer_mode_i(tmode),
        .ct_terminal_count_i(tc), .ct_square_wave_i(sq), .timer_start_o(t_s),
        .timer_halt_o(t_h), .ct_ready_clear_o(t_c), .multipurpose_out_o(pins));
    // Comparison with mismatch report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // Hang guard
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 6000) begin
            error_cnt++;
            end_sim();
        end
    end
    // One classic cycle; read data and strobe pulses taken at the ack edge
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d, input logic s);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wd, sel0} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        {q, st_s, st_h, st_c} = {dat_o, t_s, t_h, t_c};
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        wb(1'b0, a, 8'h00, 1'b1);
    endtask : rd
    // Pin check after the two-cycle path has landed
    task automatic pin(input logic [7:0] e);
        repeat (3) @(posedge clk_i);
        chk({24'h0, pins}, {24'h0, e});
    endtask : pin
    task automatic t_reset();
        pin(PINS_RESET);
        rd(OFF_PIN_STATUS);
        chk(q, 32'h000000FF);
        rd(OFF_PIN_CONFIG);
        chk(q, RDATA_ZERO);
        $display("reset test done");
    endtask : t_reset
    task automatic t_latch();
        wr(OFF_SET_STROBE, 8'hA5);
        pin(8'h5A);
        wr(OFF_SET_STROBE, 8'h01);
        wr(OFF_SET_STROBE, 8'h00);
        pin(8'h5A);
        wr(OFF_CLEAR_STROBE, 8'h81);
        pin(8'hDB);
        wb(1'b1, OFF_SET_STROBE, 8'hFF, 1'b0);
        pin(8'hDB);
        rd(6'h3C);
        chk(q, RDATA_ZERO);
        wr(OFF_CLEAR_STROBE, 8'hFF);
        pin(8'hFF);
        $display("latch test done");
    endtask : t_latch
    // Pins 2 and 3 over every source code except pin 3 counter/timer; each clock source driven both ways, the latch only asserted
    task automatic t_route();
        for (int c = 1; c < 6; c++) begin
            wr(OFF_PIN_CONFIG, (c < 4) ? 8'(c) : 8'(c - 2) << OP3_SEL_LSB);
            for (int v = 0; v < 2; v++) begin
                lvl <= (v == 1) ? 5'h01 << (c - 1) : ~(5'h01 << (c - 1));
                pin((c < 4) ? 8'hFB | 8'(v << 2) : 8'hF7 | 8'(v << 3));
            end
        end
        wr(OFF_PIN_CONFIG, 8'h00);
        wr(OFF_SET_STROBE, 8'h0C);
        pin(8'hF3);
        wr(OFF_CLEAR_STROBE, 8'h0C);
        $display("route test done");
    endtask : t_route
    task automatic t_ready();
        logic [3:0] n; // Inverse ready levels: tx A, rx A, tx B, rx B
        wr(OFF_PIN_CONFIG, 8'hF0);
        wr(OFF_SET_STROBE, 8'hF0);
        foreach (rdy[i]) begin
            n = ~(4'h1 << i);
            rdy <= ~n;
            pin({n[2], n[0], n[3], n[1], 4'hF});
        end
        rd(OFF_PIN_STATUS);
        chk({24'h0, q[23:16]}, 32'h0);
        wr(OFF_PIN_CONFIG, 8'h00);
        pin(8'hFF);
        $display("ready test done");
    endtask : t_ready
    task automatic t_counter();
        wr(OFF_PIN_CONFIG, 8'h04);
        pin(8'hFF);
        rd(OFF_START_STROBE);
        chk({31'h0, st_s}, 32'h1);
        repeat (12) @(posedge clk_i);
        chk({31'h0, pins[3]}, 32'h0);
        repeat (10) @(posedge clk_i);
        chk({31'h0, pins[3]}, 32'h0);
        rd(OFF_STOP_STROBE);
        chk({30'h0, st_h, st_c}, 32'h3);
        pin(8'hFF);
        $display("counter test done");
    endtask : t_counter
    // Count pin 3 transitions over a stretch of cycles
    task automatic toggles();
        logic p;
        t = 0;
        p = pins[3];
        repeat (30) begin
            @(posedge clk_i);
            if (pins[3] !== p) t++;
            p = pins[3];
        end
    endtask : toggles
    task automatic t_timer();
        wr(OFF_PIN_CONFIG, 8'h00);
        tmode <= 1'b1;
        rd(OFF_START_STROBE);
        wr(OFF_PIN_CONFIG, 8'h04);
        toggles();
        chk({31'h0, t >= 3}, 32'h1);
        rd(OFF_STOP_STROBE);
        chk({30'h0, st_h, st_c}, 32'h1);
        toggles();
        chk({31'h0, t >= 3}, 32'h1);
        wr(OFF_PIN_CONFIG, 8'h00);
        $display("timer test done");
    endtask : t_timer
    task automatic t_rts();
        wr(OFF_ALT_SELECT, 8'h05);
        wr(OFF_SET_STROBE, 8'h03);
        pin(8'hFF);
        wr(OFF_CHAN_A_COMMAND, 8'h80);
        pin(8'hFE);
        wr(OFF_CHAN_B_COMMAND, 8'h80);
        pin(8'hFC);
        wr(OFF_ALT_SELECT, 8'h0A);
        pin(8'hFC);
        wr(OFF_CHAN_A_COMMAND, 8'h90);
        pin(8'hFD);
        wr(OFF_CHAN_B_COMMAND, 8'h90);
        wr(OFF_ALT_SELECT, 8'h00);
        pin(8'hFF);
        $display("request-to-send test done");
    endtask : t_rts
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_latch();
        t_route();
        t_ready();
        t_counter();
        t_timer();
        t_rts();
        end_sim();
    end
endmodule : tb
